/* fsr_pkg.sv */
`default_nettype none
package fsr_pkg;
	// Opcodes
	localparam logic [7:0] OP_ID = 8'h9f;
	localparam logic [7:0] OP_PARAM = 8'h5a;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_SEC_PROG = 8'h42;
	localparam logic [7:0] OP_SEC_READ = 8'h48;
	// Frame bit counts
	localparam logic [6:0] OPCODE_BITS = 7'h08;
	localparam logic [6:0] ADDR3_BITS = 7'h18;
	localparam logic [6:0] ADDR4_BITS = 7'h20;
	localparam logic [6:0] DUMMY_BITS = 7'h08;
	localparam logic [6:0] CNT_MAX = 7'h7f;
	localparam logic [2:0] STEP_SPI = 3'h1;
	localparam logic [2:0] STEP_QPI = 3'h4;
	// Security register array
	localparam int SEC_REGS = 3;
	localparam int SEC_BYTES = 256;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// Address fields
	localparam int SEL_LSB = 12;
	localparam int SEL_MSB = 15;
	localparam int ZERO_LSB = 8;
	localparam int ZERO_MSB = 11;
	localparam int HIGH_LSB = 16;
	localparam logic [3:0] SEL_FIRST = 4'h1;
	localparam logic [3:0] SEL_LAST = 4'h3;
	// Timing
	localparam int MCLK_PERIOD_NS = 8;
	localparam int SEC_ERASE_TIME_US = 100;
	localparam int SEC_ERASE_CYCLES = SEC_ERASE_TIME_US * 1000 / MCLK_PERIOD_NS;
	// Types
	typedef enum logic [2:0]
	{
		CMD_NONE = 3'b000,
		CMD_ID = 3'b001,
		CMD_PARAM = 3'b010,
		CMD_ERASE = 3'b011,
		CMD_PROG = 3'b100,
		CMD_READ = 3'b101
	} fsr_cmd_type;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_ERASE = 2'b01,
		ST_FINISH = 2'b10
	} fsr_state_type;
	typedef struct packed
	{
		fsr_cmd_type cmd;
		logic [31:0] addr;
		logic exact;
	} fsr_frame_type;
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] data;
	} fsr_wreq_type;
endpackage
`default_nettype wire

/* fsr_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
module fsr_sync2 import fsr_pkg::*; #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

/* fsr_param_rom.sv */
`timescale 1ns/1ns
`default_nettype none
module fsr_param_rom import fsr_pkg::*; (
	// Lookup
	input wire logic [7:0] addr,
	output logic [7:0] data
);
	// Header bytes, rest of the table reads erased
	always_comb
	begin
		case (addr)
			8'h00: data = 8'h53;
			8'h01: data = 8'h46;
			8'h02: data = 8'h44;
			8'h03: data = 8'h50;
			8'h04: data = 8'h00;
			8'h05: data = 8'h01;
			8'h06: data = 8'h00;
			8'h07: data = 8'hff;
			default: data = ERASED_BYTE;
		endcase
	end
endmodule
`default_nettype wire

/* fsr_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Identity opcode returns maker, memory-type, capacity bytes, MSB first, falling edges.
// - Identity opcode is recognised in both single-line and four-line mode.
// - Parameter read: opcode, 24-bit address, 8 dummies, data from falling edge 40.
// - Parameter read always takes a 3-byte address.
// - Three independent 256-byte security registers, erased and programmed separately.
// - Address bits 15-12 pick register 1-3; bits 11-8 and above must be zero.
// - Security erase accepted only with write-enable latch set.
// - Erase runs only if select rises right after the last address byte.
// - Erase is self-timed with busy high, busy drops when it completes.
// - Finished security erase clears the write-enable latch.
// - A set lock bit guards its register; erases to it are ignored.
// - Program writes 1-256 bytes into erased cells, needs write-enable latch set.
// - Program to a locked register is ignored.
// - Security read: opcode, address, 8 dummies, then bytes MSB first until select rises.
// - Read address increments per byte, wraps from FFh to 00h.
// - Security commands take a 4-byte address in 4-byte mode, else 3-byte.
// - Security commands are recognised only in single-line mode.
module fsr_top import fsr_pkg::*; #(
	// Identity values are arbitrary
	parameter logic [7:0] MFR_ID = 8'h5c,
	parameter logic [7:0] MEM_TYPE = 8'h40,
	parameter logic [7:0] CAPACITY = 8'h19,
	parameter int ERASE_CYCLES = SEC_ERASE_CYCLES
) (
	// System clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	// Device configuration and status
	input wire logic qpi_mode,
	input wire logic addr4_mode,
	input wire logic write_enable_latch,
	input wire logic [2:0] otp_lock_bits,
	output logic busy,
	output logic latch_clear
);
	// Link side declarations
	logic frame_rst;
	logic [1:0] mode_s;
	logic qpi_s;
	logic addr4_s;
	logic [6:0] cnt;
	logic [7:0] sh;
	fsr_cmd_type cmd;
	logic [31:0] addr;
	logic [7:0] rd_ptr;
	logic [2:0] dbit;
	logic [7:0] out_sh;
	logic drive;
	fsr_frame_type rec;
	logic rd_tog;
	logic [7:0] rd_req;
	logic wr_tog;
	fsr_wreq_type wr_req;
	wire serial_in_line = io_in[0];
	wire [2:0] step = qpi_s ? STEP_QPI : STEP_SPI;
	wire [7:0] next_sh = qpi_s ? {sh[3:0], io_in} : {sh[6:0], serial_in_line};
	wire [7:0] cnt_sum = {1'b0, cnt} + {5'h00, step};
	wire [6:0] next_cnt = cnt_sum[7] ? CNT_MAX : cnt_sum[6:0];
	wire [31:0] next_addr = {addr[30:0], serial_in_line};
	wire [2:0] next_dbit = dbit + step;
	fsr_cmd_type dec_cmd;
	fsr_cmd_type next_cmd;
	logic [6:0] addr_bits;
	logic [6:0] a_end;
	logic [6:0] d_start;
	logic [7:0] byte_val;
	logic [7:0] param_byte;
	logic [7:0] sec_hold;

	// Frame reset while select is high
	assign frame_rst = cs_n | ~rstn;

	fsr_sync2 #(.W(2)) u_mode_sync (
		.clk(sclk),
		.rst_n(rstn),
		.d({qpi_mode, addr4_mode}),
		.q(mode_s)
	);
	assign qpi_s = mode_s[1];
	assign addr4_s = mode_s[0];

	// Opcode decode
	always_comb
	begin
		case (next_sh)
			OP_ID: dec_cmd = CMD_ID;
			OP_PARAM: dec_cmd = qpi_s ? CMD_NONE : CMD_PARAM;
			OP_SEC_ERASE: dec_cmd = qpi_s ? CMD_NONE : CMD_ERASE;
			OP_SEC_PROG: dec_cmd = qpi_s ? CMD_NONE : CMD_PROG;
			OP_SEC_READ: dec_cmd = qpi_s ? CMD_NONE : CMD_READ;
			default: dec_cmd = CMD_NONE;
		endcase
	end

	assign next_cmd = (next_cnt == OPCODE_BITS) ? dec_cmd : cmd;

	// Frame layout per command
	always_comb
	begin
		addr_bits = (cmd == CMD_PARAM || !addr4_s) ? ADDR3_BITS : ADDR4_BITS;
		a_end = OPCODE_BITS + addr_bits;
		case (cmd)
			CMD_ID: d_start = OPCODE_BITS;
			CMD_PARAM: d_start = a_end + DUMMY_BITS;
			CMD_READ: d_start = a_end + DUMMY_BITS;
			default: d_start = a_end;
		endcase
	end

	wire in_addr = (cmd != CMD_NONE) && (cmd != CMD_ID) && (cnt >= OPCODE_BITS) && (cnt < a_end);
	wire addr_done = in_addr && (next_cnt == a_end);
	wire in_data = (cmd != CMD_NONE) && (cnt >= d_start);
	wire is_read = (cmd == CMD_ID) || (cmd == CMD_PARAM) || (cmd == CMD_READ);
	wire prog_byte = (cmd == CMD_PROG) && in_data && (dbit == 3'h7);
	wire read_next = is_read && in_data && (dbit == 3'h0);

	// Link shift and address capture
	always_ff @(posedge sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			cnt <= '0;
			sh <= '0;
			cmd <= CMD_NONE;
			addr <= '0;
			rd_ptr <= '0;
			dbit <= '0;
		end
		else
		begin
			cnt <= next_cnt;
			sh <= next_sh;
			cmd <= next_cmd;
			if (in_addr)
				addr <= next_addr;
			if (addr_done)
				rd_ptr <= next_addr[7:0];
			else if (read_next || prog_byte)
				rd_ptr <= rd_ptr + 8'h01;
			if (in_data)
				dbit <= next_dbit;
		end
	end

	// Frame record and requests toward the system clock
	always_ff @(posedge sclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rec <= '0;
			rd_tog <= 1'b0;
			rd_req <= '0;
			wr_tog <= 1'b0;
			wr_req <= '0;
		end
		else
		begin
			rec.cmd <= next_cmd;
			if (in_addr)
				rec.addr <= next_addr;
			else if (cnt == '0)
				rec.addr <= '0;
			rec.exact <= in_addr ? addr_done : 1'b0;
			if (cmd == CMD_READ && (addr_done || read_next))
			begin
				rd_tog <= ~rd_tog;
				rd_req <= addr_done ? next_addr[7:0] : rd_ptr + 8'h01;
			end
			if (prog_byte)
			begin
				wr_tog <= ~wr_tog;
				wr_req <= '{addr: rd_ptr, data: next_sh};
			end
		end
	end

	fsr_param_rom u_param_rom (
		.addr(rd_ptr),
		.data(param_byte)
	);

	// Output byte selection
	always_comb
	begin
		case (cmd)
			CMD_ID:
			begin
				case (rd_ptr[1:0])
					2'h0: byte_val = MFR_ID;
					2'h1: byte_val = MEM_TYPE;
					2'h2: byte_val = CAPACITY;
					default: byte_val = 8'h00;
				endcase
			end
			CMD_PARAM: byte_val = param_byte;
			CMD_READ: byte_val = sec_hold;
			default: byte_val = ERASED_BYTE;
		endcase
	end

	// Falling edge output shifter
	always_ff @(negedge sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			out_sh <= '0;
			drive <= 1'b0;
		end
		else if (is_read && in_data)
		begin
			drive <= 1'b1;
			if (dbit == 3'h0)
				out_sh <= byte_val;
			else if (qpi_s)
				out_sh <= {out_sh[3:0], 4'h0};
			else
				out_sh <= {out_sh[6:0], 1'b0};
		end
	end

	assign io_out = qpi_s ? out_sh[7:4] : {2'b00, out_sh[7], 1'b0};
	assign io_oe = drive ? (qpi_s ? 4'hf : 4'h2) : 4'h0;

	// System side declarations
	logic cs_s;
	logic cs_d;
	logic [1:0] tog_s;
	logic [1:0] tog_d;
	fsr_state_type state;
	logic [31:0] erase_cnt;
	logic [1:0] erase_idx;
	logic prog_hit;
	logic [7:0] rd_byte [SEC_REGS];

	// Select level, high while selected, idles low after reset
	fsr_sync2 #(.W(1)) u_cs_sync (
		.clk(mclk),
		.rst_n(rstn),
		.d(~cs_n),
		.q(cs_s)
	);

	fsr_sync2 #(.W(2)) u_tog_sync (
		.clk(mclk),
		.rst_n(rstn),
		.d({rd_tog, wr_tog}),
		.q(tog_s)
	);

	wire cs_rise = ~cs_s & cs_d;
	wire rd_ev = tog_s[1] ^ tog_d[1];
	wire wr_ev = tog_s[0] ^ tog_d[0];
	wire [3:0] sel_code = rec.addr[SEL_MSB:SEL_LSB];
	wire sel_ok = (sel_code >= SEL_FIRST) && (sel_code <= SEL_LAST);
	wire target_ok = sel_ok && (rec.addr[ZERO_MSB:ZERO_LSB] == 4'h0)
		&& (rec.addr[31:HIGH_LSB] == 16'h0000);
	wire [1:0] idx = sel_code[1:0] - 2'h1;
	wire locked = otp_lock_bits[idx];
	wire erase_go = cs_rise && (rec.cmd == CMD_ERASE) && rec.exact && target_ok
		&& write_enable_latch && !locked && (state == ST_IDLE);
	wire write_ok = wr_ev && (rec.cmd == CMD_PROG) && target_ok
		&& write_enable_latch && !locked && (state == ST_IDLE);
	wire erase_end = (state == ST_ERASE) && (erase_cnt == 32'(ERASE_CYCLES - 1));

	// Self-timed erase sequencer
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			cs_d <= 1'b0;
			tog_d <= '0;
			state <= ST_IDLE;
			erase_cnt <= '0;
			erase_idx <= '0;
			prog_hit <= 1'b0;
			latch_clear <= 1'b0;
			sec_hold <= ERASED_BYTE;
		end
		else
		begin
			cs_d <= cs_s;
			tog_d <= tog_s;
			latch_clear <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (erase_go)
					begin
						state <= ST_ERASE;
						erase_cnt <= '0;
						erase_idx <= idx;
					end
				end
				ST_ERASE:
				begin
					erase_cnt <= erase_cnt + 32'h1;
					if (erase_end)
						state <= ST_FINISH;
				end
				ST_FINISH:
				begin
					state <= ST_IDLE;
					latch_clear <= 1'b1;
				end
				default: state <= ST_IDLE;
			endcase
			if (write_ok)
				prog_hit <= 1'b1;
			else if (cs_rise)
				prog_hit <= 1'b0;
			if (cs_rise && prog_hit)
				latch_clear <= 1'b1;
			if (rd_ev)
				sec_hold <= target_ok ? rd_byte[idx] : ERASED_BYTE;
		end
	end

	assign busy = (state != ST_IDLE);

	// Security register storage
	genvar g;
	generate
		for (g = 0; g < SEC_REGS; g = g + 1)
		begin : g_reg
			logic [7:0] cells [SEC_BYTES];
			always_ff @(posedge mclk or negedge rstn)
			begin
				if (!rstn)
				begin
					for (int i = 0; i < SEC_BYTES; i++)
						cells[i] <= ERASED_BYTE;
				end
				else if (erase_end && erase_idx == 2'(g))
				begin
					for (int i = 0; i < SEC_BYTES; i++)
						cells[i] <= ERASED_BYTE;
				end
				else if (write_ok && idx == 2'(g))
					cells[wr_req.addr] <= cells[wr_req.addr] & wr_req.data;
			end
			assign rd_byte[g] = cells[rd_req];
		end
	endgenerate
endmodule
`default_nettype wire

/* fsr_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module fsr_properties import fsr_pkg::*; #(
	parameter int ERASE_CYCLES = SEC_ERASE_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Link and status
	input wire logic cs_n,
	input wire logic [3:0] io_oe,
	input wire logic qpi_mode,
	input wire logic write_enable_latch,
	input wire logic busy,
	input wire logic latch_clear
);
	logic [15:0] busy_cnt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			busy_cnt <= 16'h0;
		else
			busy_cnt <= busy ? busy_cnt + 16'h1 : 16'h0;
	end
	oe_idle_a: assert property (cs_n && $past(cs_n) |-> io_oe == 4'h0)
		else $error("output enabled while deselected");
	spi_lane_a: assert property (!qpi_mode |-> io_oe != 4'hf)
		else $error("four lanes driven in single mode");
	qpi_lane_a: assert property (qpi_mode |-> io_oe != 4'h2)
		else $error("single lane driven in four-line mode");
	busy_len_a: assert property ($fell(busy) |-> busy_cnt == 16'(ERASE_CYCLES + 1))
		else $error("erase length wrong");
	busy_hold_a: assert property ($rose(busy) |=> busy [*8])
		else $error("busy dropped early");
	latch_end_a: assert property ($fell(busy) |-> latch_clear)
		else $error("no latch clear at erase end");
	clear_pulse_a: assert property (latch_clear |=> !latch_clear)
		else $error("latch clear longer than one cycle");
	erase_latch_a: assert property ($rose(busy) |-> $past(write_enable_latch))
		else $error("erase began without write latch");
	erase_spi_a: assert property ($rose(busy) |-> !$past(qpi_mode) && cs_n)
		else $error("erase began in wrong mode or selected");
	cover property ($rose(busy));
	cover property (latch_clear && !busy);
	cover property (io_oe == 4'hf);
endmodule
bind fsr_top fsr_properties #(.ERASE_CYCLES(ERASE_CYCLES)) u_fsr_properties (.mclk(mclk),
	.rstn(rstn), .cs_n(cs_n), .io_oe(io_oe), .qpi_mode(qpi_mode),
	.write_enable_latch(write_enable_latch), .busy(busy), .latch_clear(latch_clear));
`default_nettype wire

/* fsr_host.sv */
`timescale 1ns/1ns
`default_nettype none
module fsr_host (
	// Link
	output logic sclk,
	output logic cs_n,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out,
	// Mode
	input wire logic q
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h0;
	end
	// Mode 0 frame: clock idles low, data changes while low
	task automatic frame(input logic [79:0] tx, input int nt, input int nr,
		output logic [23:0] rx);
		rx = 24'h0;
		cs_n = 1'b0;
		for (int i = 0; i < nt + nr; i++)
		begin
			io_in = q ? tx[79:76] : {3'h5, tx[79]};
			tx = tx << (q ? 4 : 1);
			#80 sclk = 1'b1;
			if (i >= nt)
				rx = q ? {rx[19:0], io_out} : {rx[22:0], io_out[1]};
			#80 sclk = 1'b0;
		end
		#80 cs_n = 1'b1;
		io_in = ~io_in;
		#80;
	endtask
endmodule
`default_nettype wire

/* tb_fsr_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_fsr_top;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic qpi_mode = 1'b0;
	logic addr4_mode = 1'b0;
	logic write_enable_latch = 1'b0;
	logic [2:0] otp_lock_bits = 3'h0;
	logic sclk, cs_n, busy, latch_clear;
	logic [3:0] io_in, io_out, io_oe;
	logic [23:0] rx;
	int fails = 0;
	int comparisons = 0;
	initial
	begin
		forever #4 mclk = ~mclk;
	end
	// Identity values are arbitrary
	fsr_top #(.MFR_ID(8'h3a), .MEM_TYPE(8'h61), .CAPACITY(8'h17), .ERASE_CYCLES(20)) u_fsr_top (
		.mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
		.io_oe(io_oe), .qpi_mode(qpi_mode), .addr4_mode(addr4_mode),
		.write_enable_latch(write_enable_latch), .otp_lock_bits(otp_lock_bits), .busy(busy),
		.latch_clear(latch_clear));
	fsr_host u_fsr_host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
		.q(qpi_mode));
	always @(posedge mclk)
		if (latch_clear)
			write_enable_latch <= 1'b0;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic watch(input logic lvl, output logic hit, output logic wc);
		hit = 1'b0;
		wc = 1'b0;
		for (int i = 0; i < 100 && !hit; i++)
		begin
			@(negedge mclk);
			wc |= latch_clear;
			hit = (busy === lvl);
		end
	endtask
	// Apply modes, then a dummy frame to carry them into the link domain
	task automatic set_in(input logic q, input logic a4, input logic w, input logic [2:0] lk);
		@(posedge mclk);
		qpi_mode <= q;
		addr4_mode <= a4;
		write_enable_latch <= w;
		otp_lock_bits <= lk;
		@(posedge mclk);
		// Link edges kept off the system clock edges
		#3;
		u_fsr_host.frame(80'h0, q ? 2 : 8, 0, rx);
	endtask
	task automatic t_id(input logic q);
		set_in(q, 1'b0, 1'b0, 3'h0);
		u_fsr_host.frame({fsr_pkg::OP_ID, 72'h0}, q ? 2 : 8, q ? 6 : 24, rx);
		check(rx, 24'h3a6117);
	endtask
	task automatic t_param(input logic a4);
		set_in(1'b0, a4, 1'b0, 3'h0);
		u_fsr_host.frame({fsr_pkg::OP_PARAM, 24'hff, 48'h0}, 40, 24, rx);
		check(rx, 24'hff5346);
	endtask
	task automatic t_prog(input logic [23:0] a, input logic [15:0] d, input logic w,
		input logic [2:0] lk);
		set_in(1'b0, 1'b0, w, lk);
		u_fsr_host.frame({fsr_pkg::OP_SEC_PROG, a, d, 32'h0}, 48, 0, rx);
	endtask
	task automatic t_read(input logic [23:0] a, input logic [23:0] exp);
		set_in(1'b0, 1'b0, 1'b0, 3'h0);
		u_fsr_host.frame({fsr_pkg::OP_SEC_READ, a, 48'h0}, 40, 24, rx);
		check(rx, exp);
	endtask
	task automatic t_erase(input logic [31:0] a, input int nt, input logic a4,
		input logic w, input logic [2:0] lk, input logic ex);
		logic hit, wc;
		set_in(1'b0, a4, w, lk);
		u_fsr_host.frame(a4 ? {fsr_pkg::OP_SEC_ERASE, a, 40'h0}
			: {fsr_pkg::OP_SEC_ERASE, a[23:0], 48'h0}, nt, 0, rx);
		watch(1'b1, hit, wc);
		check(hit, ex);
		if (hit)
		begin
			watch(1'b0, hit, wc);
			check({hit, wc}, 2'b11);
			if (!hit)
				conclude();
		end
	endtask
	task automatic t_qpi_erase();
		logic hit, wc;
		set_in(1'b1, 1'b0, 1'b1, 3'h0);
		u_fsr_host.frame({fsr_pkg::OP_SEC_ERASE, 24'h1000, 48'h0}, 8, 0, rx);
		watch(1'b1, hit, wc);
		check(hit, 1'b0);
	endtask
	initial
	begin
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		t_id(1'b0);
		t_id(1'b1);
		t_param(1'b0);
		t_param(1'b1);
		t_prog(24'h10fe, 16'ha53c, 1'b1, 3'h0);
		t_read(24'h10fe, 24'ha53cff);
		t_prog(24'h2000, 16'h1234, 1'b1, 3'h2);
		t_read(24'h2000, 24'hffffff);
		t_prog(24'h3000, 16'h1234, 1'b0, 3'h0);
		t_read(24'h3000, 24'hffffff);
		t_qpi_erase();
		t_erase(32'h10ab, 32, 1'b0, 1'b0, 3'h0, 1'b0);
		t_erase(32'h1000, 33, 1'b0, 1'b1, 3'h0, 1'b0);
		t_erase(32'h1000, 32, 1'b0, 1'b1, 3'h1, 1'b0);
		t_erase(32'h1000, 40, 1'b1, 1'b1, 3'h0, 1'b1);
		t_read(24'h10fe, 24'hffffff);
		conclude();
	end
endmodule
`default_nettype wire
